// File: hw/dcw_control_words.sv
// What this block does
// - Status word: drive status, attention, masks
// - Offline when drive down, unsafe, unselected
// - Not ready when offline, seeking, unselected
// - Write-protect bit follows selected drive
// - Unsafe bit from drive or no selection
// - Status bits 4 and 7 read zero
// - Seek incomplete when carriage misses cylinder
// - Offset active after offset read
// - Attention bits map drives zero to three
// - Attention interrupt: idle, drive attention and mask enabled
// - Command bits control; head field increments
// - Extension bit widens command code
// - Early and late strobe requests
// - Transfer inhibit blocks memory writes
// - Head offset enable and direction
// - Head address binary, bit 15 LSB
// - Sectors-per-record field ignored
// - Start sector readable, updated in operation
// - Cylinder binary, seek first, updated
// - Invalid cylinder: seek incomplete, unit error
// - Even byte count, decremented, readable
// - 21-bit start address, updated in transfer
// - Missing memory gives bus time-out
// - Only attention masks host-writable in status
// - Writes while busy complete but ignored
// - Odd address and count rounded down
// - Words at selectable base, six words in an eight-word window
`timescale 1ns/100ps
`include "dcw_defines.svh"

module dcw_control_words
  import dcw_pkg::*;
#(
  parameter logic [19:0] BASE_WORD = `DCW_BASE_WORD
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [19:0] memAddr,
  input wire dcw_word_t memWdata,
  output dcw_word_t memRdata,
  output logic memAck,
  input wire logic ctrlBusy,
  input wire logic [3:0] extStatus,
  input wire dcw_drives_t unitSelect,
  input wire dcw_drives_t drvPowerOk,
  input wire dcw_drives_t drvSpeedOk,
  input wire dcw_drives_t drvMediaLoaded,
  input wire dcw_drives_t drvUnsafe,
  input wire dcw_drives_t drvSeeking,
  input wire dcw_drives_t drvWriteProt,
  input wire dcw_drives_t drvSeekError,
  input wire dcw_drives_t drvAttention,
  input wire logic cmdStart,
  input wire logic offsetReadDone,
  input wire logic cylinderInvalid,
  input wire logic memNoResponse,
  input wire logic headStep,
  input wire logic sectorStep,
  input wire logic cylinderStep,
  input wire logic countStep,
  input wire logic addrStep,
  output logic attentionIrq,
  output logic commandExtension,
  output logic [2:0] commandCode,
  output logic strobeEarly,
  output logic strobeLate,
  output logic memoryWriteAllow,
  output logic headOffsetEnable,
  output logic offsetForward,
  output logic [5:0] headAddress,
  output logic [7:0] startSector,
  output dcw_word_t startCylinder,
  output dcw_word_t transferByteCount,
  output dcw_word_t startMemoryAddressLow,
  output logic addrCarry,
  output logic unitErrorSet,
  output logic opTerminate,
  output logic busTimeoutError
);

  // Drive cable lines: two-stage synchroniser
  logic [31:0] drvMeta;
  logic [31:0] drvSync;
  dcw_drives_t syPower;
  dcw_drives_t sySpeed;
  dcw_drives_t syMedia;
  dcw_drives_t syUnsafe;
  dcw_drives_t sySeeking;
  dcw_drives_t syProt;
  dcw_drives_t sySeekErr;
  dcw_drives_t syAttn;

  dcw_word_t unitStatus;
  dcw_drives_t attnMask;
  dcw_word_t commandWord;
  logic [7:0] sectorsPerRecord;
  logic seekIncompleteFlag;
  logic offsetActiveFlag;

  logic hit;
  logic [2:0] wordIdx;
  logic hostWr;

  // True when any selected drive shows the line
  function automatic logic selLine(input dcw_drives_t lines,
                                   input dcw_drives_t sel);
    selLine = |(lines & sel);
  endfunction : selLine

  // True when an idle host write targets the given word
  function automatic logic wrWord(input logic [2:0] idx);
    wrWord = hostWr && (wordIdx == idx);
  endfunction : wrWord

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drvMeta <= 32'h00000000;
      drvSync <= 32'h00000000;
    end else begin
      drvMeta <= {drvPowerOk, drvSpeedOk, drvMediaLoaded, drvUnsafe,
                  drvSeeking, drvWriteProt, drvSeekError, drvAttention};
      drvSync <= drvMeta;
    end
  end

  assign {syPower, sySpeed, syMedia, syUnsafe,
          sySeeking, syProt, sySeekErr, syAttn} = drvSync;

  // Base decode over the first six words of the eight-word window
  assign hit = memReq && (memAddr[19:3] == BASE_WORD[19:3]) &&
               (memAddr[2:0] <= `DCW_IDX_ADDR_LOW);
  assign wordIdx = memAddr[2:0];
  // A busy controller acknowledges but never stores
  assign hostWr = hit && memWrite && !ctrlBusy;

  // Live status, rebuilt every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitStatus <= `DCW_RST_WORD;
    end else begin
      logic noSel;
      logic offl;
      noSel = (unitSelect == `DCW_RST_MASK);
      offl = noSel || selLine(syUnsafe, unitSelect) ||
             !selLine(syPower & sySpeed & syMedia, unitSelect);
      unitStatus <= `DCW_RST_WORD;
      unitStatus[`DCW_US_OFFLINE] <= offl;
      unitStatus[`DCW_US_NOT_READY] <= offl || noSel ||
        selLine(sySeeking, unitSelect);
      unitStatus[`DCW_US_WRITE_PROT] <= selLine(syProt, unitSelect);
      unitStatus[`DCW_US_UNSAFE] <= noSel ||
        selLine(syUnsafe, unitSelect);
      unitStatus[`DCW_US_SEEK_INC] <= seekIncompleteFlag ||
        selLine(sySeekErr, unitSelect);
      unitStatus[`DCW_US_OFFSET_ACT] <= offsetActiveFlag;
      for (int i = 0; i < 4; i++) begin
        unitStatus[`DCW_US_DRIVE_ATTENTION_HI - i] <= syAttn[i];
        unitStatus[`DCW_US_MASK_HI - i] <= attnMask[i];
      end
    end
  end

  // Attention masks are the only host-writable status bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attnMask <= `DCW_RST_MASK;
    end else if (wrWord(`DCW_IDX_UNIT_STATUS)) begin
      for (int i = 0; i < 4; i++) begin
        attnMask[i] <= memWdata[`DCW_US_MASK_HI - i];
      end
    end
  end

  // Sticky seek flag; a new command clears, an event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seekIncompleteFlag <= 1'b0;
    end else if (cylinderInvalid) begin
      seekIncompleteFlag <= 1'b1;
    end else if (cmdStart) begin
      seekIncompleteFlag <= 1'b0;
    end
  end

  // Sticky offset flag; an event in the clearing cycle is not lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offsetActiveFlag <= 1'b0;
    end else if (offsetReadDone) begin
      offsetActiveFlag <= 1'b1;
    end else if (cmdStart) begin
      offsetActiveFlag <= 1'b0;
    end
  end

  // Unit error report; the word-7 logic keeps the sticky copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unitErrorSet <= 1'b0;
    end else begin
      unitErrorSet <= cylinderInvalid;
    end
  end

  // Either failure ends the running operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opTerminate <= 1'b0;
    end else begin
      opTerminate <= cylinderInvalid || memNoResponse;
    end
  end

  // Bus time-out report
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busTimeoutError <= 1'b0;
    end else begin
      busTimeoutError <= memNoResponse;
    end
  end

  // Attention interrupt only while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      attentionIrq <= 1'b0;
    end else begin
      attentionIrq <= !ctrlBusy && |(syAttn & attnMask);
    end
  end

  // Command word; head field advances during the operation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commandWord <= `DCW_RST_WORD;
    end else if (wrWord(`DCW_IDX_COMMAND)) begin
      commandWord <= memWdata;
    end else if (headStep) begin
      commandWord[`DCW_CW_HEAD_HI:0] <=
        commandWord[`DCW_CW_HEAD_HI:0] + 6'h01;
    end
  end

  // Command fields drive the engine and drive cable through one register stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      commandExtension <= 1'b0;
      commandCode <= 3'h0;
      strobeEarly <= 1'b0;
      strobeLate <= 1'b0;
      memoryWriteAllow <= 1'b1;
    end else begin
      commandExtension <= commandWord[`DCW_CW_EXT];
      commandCode <=
        commandWord[`DCW_CW_CODE_HI:`DCW_CW_CODE_LO];
      strobeEarly <= commandWord[`DCW_CW_STROBE_EARLY];
      strobeLate <= commandWord[`DCW_CW_STROBE_LATE];
      memoryWriteAllow <= !commandWord[`DCW_CW_INHIBIT];
    end
  end

  // Head positioning fields for the drive cable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      headOffsetEnable <= 1'b0;
      offsetForward <= 1'b0;
      headAddress <= 6'h00;
    end else begin
      headOffsetEnable <= commandWord[`DCW_CW_OFS_EN];
      // Direction is meaningless with offset off, so hold backward
      offsetForward <= commandWord[`DCW_CW_OFS_EN] &&
                       commandWord[`DCW_CW_OFS_FWD];
      headAddress <= commandWord[`DCW_CW_HEAD_HI:0];
    end
  end

  // Record field kept for read-back only, never used by the engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sectorsPerRecord <= 8'h00;
    end else if (wrWord(`DCW_IDX_SECTOR)) begin
      sectorsPerRecord <= memWdata[15:8];
    end
  end

  // Start sector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startSector <= 8'h00;
    end else if (wrWord(`DCW_IDX_SECTOR)) begin
      startSector <= memWdata[`DCW_SW_SECTOR_HI:0];
    end else if (sectorStep) begin
      startSector <= startSector + 8'h01;
    end
  end

  // Cylinder word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startCylinder <= `DCW_RST_WORD;
    end else if (wrWord(`DCW_IDX_CYLINDER)) begin
      startCylinder <= memWdata;
    end else if (cylinderStep) begin
      startCylinder <= startCylinder + 16'h0001;
    end
  end

  // Byte count: odd values lose the low bit; stops at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transferByteCount <= `DCW_RST_WORD;
    end else if (wrWord(`DCW_IDX_BYTE_COUNT)) begin
      transferByteCount <= {memWdata[15:1], 1'b0};
    end else if (countStep && transferByteCount != `DCW_RST_WORD) begin
      transferByteCount <= transferByteCount - `DCW_WORD_BYTES;
    end
  end

  // Low address; carry tells the high word holder to advance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startMemoryAddressLow <= `DCW_RST_WORD;
      addrCarry <= 1'b0;
    end else begin
      addrCarry <= 1'b0;
      if (wrWord(`DCW_IDX_ADDR_LOW)) begin
        startMemoryAddressLow <= {memWdata[15:1], 1'b0};
      end else if (addrStep) begin
        startMemoryAddressLow <=
          startMemoryAddressLow + `DCW_WORD_BYTES;
        addrCarry <= (startMemoryAddressLow[15:1] == 15'h7FFF);
      end
    end
  end

  // Every hit is acknowledged, busy or not, so the host never hangs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
    end else begin
      memAck <= hit;
    end
  end

  // Read path; busy reads return the four extended status bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memRdata <= `DCW_RST_WORD;
    end else begin
      memRdata <= `DCW_RST_WORD;
      if (hit && !memWrite) begin
        if (ctrlBusy) begin
          memRdata[15:12] <= extStatus;
        end else begin
          unique case (wordIdx)
            `DCW_IDX_UNIT_STATUS: memRdata <= unitStatus;
            `DCW_IDX_COMMAND: memRdata <= commandWord;
            `DCW_IDX_SECTOR: memRdata <= {sectorsPerRecord, startSector};
            `DCW_IDX_CYLINDER: memRdata <= startCylinder;
            `DCW_IDX_BYTE_COUNT: memRdata <= transferByteCount;
            default: memRdata <= startMemoryAddressLow;
          endcase
        end
      end
    end
  end

endmodule : dcw_control_words

// File: hw/dcw_defines.svh
`ifndef DCW_DEFINES_SVH
`define DCW_DEFINES_SVH
// Word indices within the eight-word window
`define DCW_IDX_UNIT_STATUS 3'h0
`define DCW_IDX_COMMAND 3'h1
`define DCW_IDX_SECTOR 3'h2
`define DCW_IDX_CYLINDER 3'h3
`define DCW_IDX_BYTE_COUNT 3'h4
`define DCW_IDX_ADDR_LOW 3'h5
// Default word address of word zero (multiple of eight)
`define DCW_BASE_WORD 20'h7C400
// Unit status word, vector bit = 15 - documented bit
`define DCW_US_OFFLINE 15
`define DCW_US_NOT_READY 14
`define DCW_US_WRITE_PROT 13
`define DCW_US_UNSAFE 12
`define DCW_US_SEEK_INC 10
`define DCW_US_OFFSET_ACT 9
`define DCW_US_DRIVE_ATTENTION_HI 7
`define DCW_US_MASK_HI 3
// Command word
`define DCW_CW_EXT 15
`define DCW_CW_STROBE_EARLY 13
`define DCW_CW_STROBE_LATE 12
`define DCW_CW_INHIBIT 11
`define DCW_CW_CODE_HI 10
`define DCW_CW_CODE_LO 8
`define DCW_CW_OFS_EN 7
`define DCW_CW_OFS_FWD 6
`define DCW_CW_HEAD_HI 5
// Sector word
`define DCW_SW_SECTOR_HI 7
// Reset values
`define DCW_RST_WORD 16'h0000
`define DCW_RST_MASK 4'h0
// Step of count and address per two-byte word
`define DCW_WORD_BYTES 16'h0002
`endif

// File: hw/dcw_pkg.sv
package dcw_pkg;
  typedef logic [15:0] dcw_word_t;
  typedef logic [3:0] dcw_drives_t;
endpackage : dcw_pkg

// File: sim/dcw_control_words_properties.sv
`timescale 1ns/100ps
module dcw_control_words_properties
  import dcw_pkg::*;
#(
  parameter logic [19:0] BASE_WORD = 20'h7C400
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [19:0] memAddr,
  input wire dcw_word_t memRdata,
  input wire logic memAck,
  input wire logic ctrlBusy,
  input wire logic [3:0] extStatus,
  input wire logic cylinderInvalid,
  input wire logic memNoResponse,
  input wire logic sectorStep,
  input wire logic countStep,
  input wire logic addrStep,
  input wire logic attentionIrq,
  input wire logic [7:0] startSector,
  input wire dcw_word_t transferByteCount,
  input wire dcw_word_t startMemoryAddressLow,
  input wire logic addrCarry,
  input wire logic unitErrorSet,
  input wire logic opTerminate,
  input wire logic busTimeoutError
);
  logic hit;
  assign hit = memAddr[19:3] == BASE_WORD[19:3] && memAddr[2:0] <= 3'h5;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_hit: assert property (memReq && hit |=> memAck)
    else $error("hit not acknowledged");
  a_ack_miss: assert property (memReq && !hit |=> !memAck)
    else $error("miss acknowledged");
  a_busy_read: assert property (memReq && hit && !memWrite && ctrlBusy
    |=> memRdata == {$past(extStatus), 12'h000})
    else $error("busy read not extended status");
  a_irq_busy: assert property (ctrlBusy |=> !attentionIrq)
    else $error("attention irq while busy");
  a_cyl_bad: assert property (cylinderInvalid |=> unitErrorSet && opTerminate)
    else $error("invalid cylinder not reported");
  a_mem_timeout: assert property (memNoResponse |=> busTimeoutError)
    else $error("bus time-out not reported");
  // Host write of the same word wins, so only idle-bus steps are judged
  a_count_down: assert property (countStep && !memReq
    && transferByteCount != 16'h0000
    |=> transferByteCount == $past(transferByteCount) - 16'h0002)
    else $error("byte count not decremented");
  a_sector_step: assert property (sectorStep && !memReq
    |=> startSector == $past(startSector) + 8'h01)
    else $error("sector not stepped");
  a_addr_wrap: assert property (addrStep && !memReq
    && startMemoryAddressLow == 16'hFFFE
    |=> addrCarry && startMemoryAddressLow == 16'h0000)
    else $error("address wrap without carry");
  c_write: cover property (memReq && memWrite && hit);
  c_irq: cover property (attentionIrq);
  c_wrap: cover property (addrCarry);
endmodule : dcw_control_words_properties

bind dcw_control_words dcw_control_words_properties #(.BASE_WORD(BASE_WORD))
  i_dcw_control_words_properties (.clk, .rst_n, .memReq, .memWrite,
  .memAddr, .memRdata, .memAck, .ctrlBusy, .extStatus, .cylinderInvalid,
  .memNoResponse, .sectorStep, .countStep, .addrStep, .attentionIrq,
  .startSector, .transferByteCount, .startMemoryAddressLow, .addrCarry,
  .unitErrorSet, .opTerminate, .busTimeoutError);

// File: sim/dcw_host_model.sv
`timescale 1ns/100ps
module dcw_host_model
  import dcw_pkg::*;
#(
  parameter logic [19:0] BASE_WORD = 20'h7C400
) (
  input wire logic clk,
  output logic memReq,
  output logic memWrite,
  output logic [19:0] memAddr,
  output dcw_word_t memWdata,
  input wire dcw_word_t memRdata,
  input wire logic memAck
);
  initial begin
    {memReq, memWrite, memAddr, memWdata} = '0;
  end
  task automatic xfer(input logic w, input logic [2:0] idx,
    input dcw_word_t d, output dcw_word_t q, output logic k);
    @(negedge clk);
    memReq = 1'b1;
    memWrite = w;
    memAddr = {BASE_WORD[19:3], idx};
    memWdata = d;
    @(negedge clk);
    memReq = 1'b0;
    // Released lines flip so a stale value never passes for data
    memWrite = ~memWrite;
    memAddr = ~memAddr;
    memWdata = ~memWdata;
    q = memRdata;
    k = memAck;
  endtask : xfer
endmodule : dcw_host_model

// File: sim/dcw_control_words_tb_top.sv
`timescale 1ns/100ps
`include "dcw_defines.svh"
module dcw_control_words_tb_top
  import dcw_pkg::*;
;
  logic clk, rst_n, ctrlBusy, cmdStart, offsetReadDone, cylinderInvalid;
  logic memNoResponse, headStep, sectorStep, cylinderStep, countStep;
  logic addrStep, memReq, memWrite, memAck, attentionIrq, commandExtension;
  logic strobeEarly, strobeLate, memoryWriteAllow, headOffsetEnable;
  logic offsetForward, addrCarry, unitErrorSet, opTerminate, busTimeoutError;
  logic [2:0] commandCode;
  logic [3:0] extStatus;
  logic [5:0] headAddress;
  logic [7:0] startSector;
  logic [10:0] cwOut;
  logic [19:0] memAddr;
  dcw_word_t memWdata, memRdata, startCylinder, transferByteCount;
  dcw_word_t startMemoryAddressLow;
  dcw_drives_t unitSelect, drvPowerOk, drvMediaLoaded, drvUnsafe, msk;
  dcw_drives_t drvSeeking, drvWriteProt, drvAttention;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  assign cwOut = {strobeEarly, strobeLate, memoryWriteAllow,
    headOffsetEnable, offsetForward, headAddress};
  dcw_host_model #(.BASE_WORD(`DCW_BASE_WORD)) i_dcw_host_model (.clk,
    .memReq, .memWrite, .memAddr, .memWdata, .memRdata, .memAck);
  dcw_control_words #(.BASE_WORD(`DCW_BASE_WORD)) i_dcw_control_words (
    .clk, .rst_n, .memReq, .memWrite, .memAddr, .memWdata, .memRdata,
    .memAck, .ctrlBusy, .extStatus, .unitSelect, .drvPowerOk,
    .drvSpeedOk(4'hF), .drvMediaLoaded, .drvUnsafe, .drvSeeking,
    .drvWriteProt, .drvSeekError(4'h0), .drvAttention, .cmdStart,
    .offsetReadDone, .cylinderInvalid, .memNoResponse, .headStep,
    .sectorStep, .cylinderStep, .countStep, .addrStep, .attentionIrq,
    .commandExtension, .commandCode, .strobeEarly, .strobeLate,
    .memoryWriteAllow, .headOffsetEnable, .offsetForward, .headAddress,
    .startSector, .startCylinder, .transferByteCount,
    .startMemoryAddressLow, .addrCarry, .unitErrorSet, .opTerminate,
    .busTimeoutError);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic chk(input dcw_word_t s, input dcw_word_t e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [2:0] a, input dcw_word_t d,
    input dcw_word_t e, input logic ek);
    dcw_word_t q;
    logic k;
    i_dcw_host_model.xfer(w, a, d, q, k);
    chk(16'(k), 16'(ek));
    if (!w) chk(q, e);
  endtask : acc
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  function automatic dcw_word_t expSt(input logic si, input logic os);
    logic off, none;
    none = unitSelect == 4'h0;
    off = none || |(unitSelect & (~drvPowerOk | ~drvMediaLoaded | drvUnsafe));
    return {off, off || |(unitSelect & drvSeeking), |(unitSelect &
      drvWriteProt), none || |(unitSelect & drvUnsafe), 1'b0, si, os, 1'b0,
      drvAttention[0], drvAttention[1], drvAttention[2], drvAttention[3],
      msk[0], msk[1], msk[2], msk[3]};
  endfunction : expSt
  initial begin
    {rst_n, ctrlBusy, cmdStart, offsetReadDone, cylinderInvalid} = '0;
    {memNoResponse, headStep, sectorStep, cylinderStep, countStep} = '0;
    {addrStep, extStatus, unitSelect, drvUnsafe, msk} = '0;
    {drvSeeking, drvWriteProt, drvAttention} = '0;
    drvPowerOk = 4'hF;
    drvMediaLoaded = 4'hF;
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk(16'(memoryWriteAllow), 16'h0001);
    for (int i = 1; i < 6; i++) acc(1'b0, 3'(i), 16'h0, 16'h0, 1'b1);
    acc(1'b0, 3'h0, 16'h0, expSt(1'b0, 1'b0), 1'b1);
    acc(1'b1, 3'h0, 16'hFFF5, 16'h0, 1'b1);
    msk = 4'hA;
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      unitSelect = 4'h1 << i[1:0];
      drvPowerOk = i[2] ? 4'h5 : 4'hF;
      drvMediaLoaded = i[1] ? 4'h7 : 4'hF;
      drvUnsafe = i[3] ? 4'h6 : 4'h0;
      drvSeeking = i[0] ? 4'hA : 4'h0;
      drvWriteProt = 4'hC;
      drvAttention = 4'(i);
      repeat (4) @(negedge clk);
      acc(1'b0, 3'h0, 16'h0, expSt(1'b0, 1'b0), 1'b1);
      chk(16'(attentionIrq), 16'(|(drvAttention & msk)));
    end
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 3'h1, {i[3], 4'h0, i[2:0], 8'h00}, 16'h0, 1'b1);
      @(negedge clk);
      chk(16'({commandExtension, commandCode}), 16'(i));
    end
    acc(1'b1, 3'h1, 16'h30C5, 16'h0, 1'b1);
    @(negedge clk);
    chk(16'(cwOut), 16'h07C5);
    acc(1'b1, 3'h1, 16'h0845, 16'h0, 1'b1);
    pulse(headStep);
    @(negedge clk);
    chk(16'(cwOut), 16'h0006);
    acc(1'b0, 3'h1, 16'h0, 16'h0846, 1'b1);
    acc(1'b1, 3'h2, 16'hAB12, 16'h0, 1'b1);
    pulse(sectorStep);
    acc(1'b0, 3'h2, 16'h0, 16'hAB13, 1'b1);
    chk(16'(startSector), 16'h0013);
    acc(1'b1, 3'h3, 16'hFFFF, 16'h0, 1'b1);
    pulse(cylinderStep);
    acc(1'b0, 3'h3, 16'h0, 16'h0000, 1'b1);
    acc(1'b1, 3'h4, 16'h0005, 16'h0, 1'b1);
    acc(1'b0, 3'h4, 16'h0, 16'h0004, 1'b1);
    repeat (3) pulse(countStep);
    acc(1'b0, 3'h4, 16'h0, 16'h0000, 1'b1);
    acc(1'b1, 3'h5, 16'hFFFF, 16'h0, 1'b1);
    acc(1'b0, 3'h5, 16'h0, 16'hFFFE, 1'b1);
    pulse(addrStep);
    chk(16'(addrCarry), 16'h0001);
    acc(1'b0, 3'h5, 16'h0, 16'h0000, 1'b1);
    pulse(cylinderInvalid);
    chk(16'({unitErrorSet, opTerminate}), 16'h0003);
    pulse(offsetReadDone);
    acc(1'b0, 3'h0, 16'h0, expSt(1'b1, 1'b1), 1'b1);
    pulse(cmdStart);
    acc(1'b0, 3'h0, 16'h0, expSt(1'b0, 1'b0), 1'b1);
    pulse(memNoResponse);
    chk(16'({busTimeoutError, opTerminate}), 16'h0003);
    @(negedge clk);
    ctrlBusy = 1'b1;
    extStatus = 4'hA;
    acc(1'b1, 3'h3, 16'h1234, 16'h0, 1'b1);
    acc(1'b0, 3'h3, 16'h0, 16'hA000, 1'b1);
    chk(16'(attentionIrq), 16'h0000);
    @(negedge clk) ctrlBusy = 1'b0;
    acc(1'b0, 3'h3, 16'h0, 16'h0000, 1'b1);
    acc(1'b0, 3'h6, 16'h0, 16'h0000, 1'b0);
    print_verdict();
  end
endmodule : dcw_control_words_tb_top
